// ===== include/apd_consts.svh
`ifndef APD_CONSTS_SVH
`define APD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Prebyte codes
// ----------------------------------------------------------------------------
`define APD_PFX_NONE 8'h00
`define APD_PFX_SWAP 8'h90
`define APD_PFX_INDY 8'h91
`define APD_PFX_IND  8'h92

// ----------------------------------------------------------------------------
// Opcode map: the high nibble selects the addressing row
// ----------------------------------------------------------------------------
`define APD_ROW_BTJ   4'h0
`define APD_ROW_BIT   4'h1
`define APD_ROW_JR    4'h2
`define APD_ROW_RMWD  4'h3
`define APD_ROW_RMWA  4'h4
`define APD_ROW_RMWX  4'h5
`define APD_ROW_RMWS  4'h6
`define APD_ROW_RMW0  4'h7
`define APD_ROW_INH8  4'h8
`define APD_ROW_INH9  4'h9
`define APD_ROW_IMM   4'hA
`define APD_ROW_SDIR  4'hB
`define APD_ROW_LDIR  4'hC
`define APD_ROW_LIDX  4'hD
`define APD_ROW_SIDX  4'hE
`define APD_ROW_IDX0  4'hF
`define APD_OP_MUL    8'h42
`define APD_OP_RELATIVE_CALL  8'hAD
`define APD_RMW_LEGAL 16'hF7D9
`define APD_ALU_LEGAL 16'hFFFF
`define APD_IMM_LEGAL 16'hEF7F
`define APD_INH8_LEGAL 16'hC77B
`define APD_INH9_LEGAL 16'hFFF8

// ----------------------------------------------------------------------------
// Field widths and fixed values
// ----------------------------------------------------------------------------
`define APD_IDX_W     8
`define APD_PAGE_ZERO 8'h00
`define APD_ADDR_ONE  16'h0001
`define APD_LEN_ONE   3'h1

`endif

// ===== include/apd_pkg.sv
package apd_pkg;

  // Seventeen addressing modes the decoder can resolve.
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_SDIR, M_LDIR, M_IDX0, M_SIDX, M_LIDX,
    M_SIND, M_LIND, M_SIIDX, M_LIIDX, M_RELD, M_RELI,
    M_BITD, M_BITI, M_BITDR, M_BITIR
  } apd_mode_t;

  // Thirteen functional instruction groups.
  typedef enum logic [3:0] {
    G_LOAD, G_STACK, G_INCDEC, G_CMP, G_LOGIC, G_BIT, G_BTJ,
    G_ARITH, G_SHIFT, G_JUMP, G_COND, G_INT, G_FLAG
  } apd_group_t;

  // Decoder sequencing states.
  typedef enum logic [2:0] {
    S_IDLE, S_OP, S_B1, S_B2, S_PH, S_PL, S_CALC
  } apd_state_t;

  // Static decode of one prebyte and opcode pair.
  typedef struct packed {
    apd_mode_t  mode;
    apd_group_t group;
    logic [1:0] nops;
    logic       legal;
    logic       combo_ok;
    logic       use_y;
  } apd_dec_t;

  // Finished decode handed to the execution side.
  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [15:0] next_pc;
    logic [7:0]  operand;
    logic [7:0]  opcode;
    logic [7:0]  prefix;
    apd_mode_t   mode;
    apd_group_t  group;
    logic [2:0]  len;
    logic        use_y;
    logic        combo_bad;
  } apd_result_t;

endpackage

// ===== src/apd_decoder.sv
// Contract
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed: unsigned index plus offset
// - No offset: address equals index value
// - Short indexed: byte offset plus index
// - Long indexed: word offset plus index
// - Indirect: fetch operand address via pointer
// - Short indirect: byte pointer, page zero
// - Indirect indexed: pointer value plus index
// - Indirect indexed: byte or word pointer
// - Relative: PC plus sign-extended byte
// - Relative offset direct, or fetched indirectly
// - Long forms only for ALU-type instructions
// - Instruction length one to four bytes
// - Three prebytes recognised before opcode
// - Prebyte 90 swaps to second index
// - Prebyte 92 makes direct forms indirect
// - Prebyte 92 makes short and long indexed indirect indexed
// - Prebyte 91 uses second index indirectly
// - Decode all 63 instructions, 13 groups
// - Unknown code raises the illegal reset
// - Bad prebyte pairing raises no reset
// - Immediate: opcode then operand byte
`include "apd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module apd_decoder #(
  parameter logic [15:0] INH8_LEGAL = `APD_INH8_LEGAL,
  parameter logic [15:0] INH9_LEGAL = `APD_INH9_LEGAL,
  parameter int          IDX_W      = `APD_IDX_W
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                start,
  input  wire logic [15:0]         start_pc,
  input  wire logic                code_valid,
  input  wire logic [7:0]          code_data,
  input  wire logic                data_valid,
  input  wire logic [7:0]          data_rdata,
  input  wire logic [7:0]          idx_x,
  input  wire logic [7:0]          idx_y,
  output logic                     code_req,
  output logic [15:0]              code_addr,
  output logic                     data_req,
  output logic [15:0]              data_addr,
  output logic                     busy,
  output logic                     done,
  output logic                     illegal_rst,
  output apd_pkg::apd_result_t     result
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The address arithmetic is built for byte-wide index registers only.
  if (IDX_W != 8) begin : g_bad_idx
    $error("apd_decoder supports only 8-bit index registers.");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  apd_pkg::apd_state_t state_ff;      // Sequencer state.
  apd_pkg::apd_dec_t   dec_ff;        // Decode of the current instruction.
  apd_pkg::apd_dec_t   dec_now;       // Decode of the byte on code_data.
  logic [15:0]         pc_ff;         // Address of the next code byte.
  logic [7:0]          pfx_ff;        // Prebyte seen, zero when none.
  logic [7:0]          op_ff;         // Opcode byte.
  logic [7:0]          b1_ff;         // First byte after the opcode.
  logic [7:0]          b2_ff;         // Second byte after the opcode.
  logic [7:0]          ph_ff;         // Pointer byte at the pointer address.
  logic [7:0]          pl_ff;         // Pointer byte at pointer address + 1.
  logic [15:0]         daddr_ff;      // Data read address.
  logic [2:0]          len_ff;        // Bytes taken so far.
  logic                done_ff;       // Result-ready pulse.
  logic                ill_ff;        // Illegal-code reset pulse.
  logic                is_pfx;        // The byte on code_data is a prebyte.
  logic                need_ptr;      // Mode reads a pointer from data memory.
  logic                word_ptr;      // That pointer is a word.
  logic [7:0]          idx;           // Selected index register.
  logic [15:0]         rel_base;      // Sign-extended relative offset.
  logic [15:0]         ea_calc;       // Effective address being formed.
  logic [15:0]         tgt_calc;      // Branch target being formed.
  logic [7:0]          rel_off;       // Relative offset byte in use.

  // --------------------------------------------------------------------------
  // Opcode decode
  // --------------------------------------------------------------------------
  // Legal-opcode masks, one bit per low nibble of the row.
  localparam logic [15:0] RMW_LEGAL = `APD_RMW_LEGAL;
  localparam logic [15:0] ALU_LEGAL = `APD_ALU_LEGAL;
  localparam logic [15:0] IMM_LEGAL = `APD_IMM_LEGAL;
  // Base mode from the opcode row, then the prebyte rewrites it. A bad
  // pairing keeps the unprefixed meaning and is only flagged, never reset.
  function automatic apd_pkg::apd_dec_t apd_decode(input logic [7:0] pfx,
                                                   input logic [7:0] op);
    apd_pkg::apd_dec_t d;
    logic [3:0]        lo;
    lo         = op[3:0];
    d.mode     = apd_pkg::M_INH;
    d.group    = apd_pkg::G_LOAD;
    d.legal    = 1'b1;
    d.combo_ok = 1'b1;
    d.use_y    = 1'b0;
    case (op[7:4])
      `APD_ROW_BTJ: begin
        d.mode  = apd_pkg::M_BITDR;
        d.group = apd_pkg::G_BTJ;
      end
      `APD_ROW_BIT: begin
        d.mode  = apd_pkg::M_BITD;
        d.group = apd_pkg::G_BIT;
      end
      `APD_ROW_JR: begin
        d.mode  = apd_pkg::M_RELD;
        d.group = (lo < 4'h2) ? apd_pkg::G_JUMP : apd_pkg::G_COND;
      end
      `APD_ROW_INH8: begin
        d.legal = INH8_LEGAL[lo];
        d.group = (lo == 4'h1) ? apd_pkg::G_JUMP :
                  (lo >= 4'h4 && lo <= 4'hA) ? apd_pkg::G_STACK : apd_pkg::G_INT;
      end
      `APD_ROW_INH9: begin
        d.legal = INH9_LEGAL[lo];
        d.group = (lo >= 4'h8 && lo <= 4'hB) ? apd_pkg::G_FLAG :
                  (lo == 4'hC) ? apd_pkg::G_STACK :
                  (lo == 4'hD) ? apd_pkg::G_JUMP : apd_pkg::G_LOAD;
      end
      `APD_ROW_RMWD, `APD_ROW_RMWA, `APD_ROW_RMWX,
      `APD_ROW_RMWS, `APD_ROW_RMW0: begin
        d.legal = RMW_LEGAL[lo] | (op == `APD_OP_MUL);
        d.mode  = (op[7:4] == `APD_ROW_RMWD) ? apd_pkg::M_SDIR :
                  (op[7:4] == `APD_ROW_RMWS) ? apd_pkg::M_SIDX :
                  (op[7:4] == `APD_ROW_RMW0) ? apd_pkg::M_IDX0 : apd_pkg::M_INH;
        case (lo)
          4'h0, 4'h3: d.group = apd_pkg::G_LOGIC;
          4'h2:       d.group = apd_pkg::G_ARITH;
          4'hA, 4'hC: d.group = apd_pkg::G_INCDEC;
          4'hD:       d.group = apd_pkg::G_CMP;
          4'hF:       d.group = apd_pkg::G_LOAD;
          default:    d.group = apd_pkg::G_SHIFT;
        endcase
      end
      default: begin
        d.legal = (op[7:4] == `APD_ROW_IMM) ? IMM_LEGAL[lo] : ALU_LEGAL[lo];
        case (op[7:4])
          `APD_ROW_IMM:  d.mode = apd_pkg::M_IMM;
          `APD_ROW_SDIR: d.mode = apd_pkg::M_SDIR;
          `APD_ROW_LDIR: d.mode = apd_pkg::M_LDIR;
          `APD_ROW_LIDX: d.mode = apd_pkg::M_LIDX;
          `APD_ROW_SIDX: d.mode = apd_pkg::M_SIDX;
          default:       d.mode = apd_pkg::M_IDX0;
        endcase
        case (lo)
          4'h0, 4'h2, 4'h9, 4'hB: d.group = apd_pkg::G_ARITH;
          4'h1, 4'h3, 4'h5:       d.group = apd_pkg::G_CMP;
          4'h4, 4'h8, 4'hA:       d.group = apd_pkg::G_LOGIC;
          4'hC, 4'hD:             d.group = apd_pkg::G_JUMP;
          default:                d.group = apd_pkg::G_LOAD;
        endcase
        if (op == `APD_OP_RELATIVE_CALL) begin
          d.mode  = apd_pkg::M_RELD;
          d.legal = 1'b1;
        end
      end
    endcase
    // A prebyte in the opcode slot is a valid code in a bad pairing.
    if (op == `APD_PFX_SWAP || op == `APD_PFX_INDY || op == `APD_PFX_IND) begin
      d.legal    = 1'b1;
      d.combo_ok = 1'b0;
      d.mode     = apd_pkg::M_INH;
    end else begin
      case (pfx)
        `APD_PFX_SWAP: begin
          d.use_y    = 1'b1;
          d.combo_ok = (d.mode <= apd_pkg::M_LIDX);
        end
        `APD_PFX_IND: begin
          case (d.mode)
            apd_pkg::M_SDIR:  d.mode = apd_pkg::M_SIND;
            apd_pkg::M_LDIR:  d.mode = apd_pkg::M_LIND;
            apd_pkg::M_RELD:  d.mode = apd_pkg::M_RELI;
            apd_pkg::M_BITD:  d.mode = apd_pkg::M_BITI;
            apd_pkg::M_BITDR: d.mode = apd_pkg::M_BITIR;
            apd_pkg::M_SIDX:  d.mode = apd_pkg::M_SIIDX;
            apd_pkg::M_LIDX:  d.mode = apd_pkg::M_LIIDX;
            default:          d.combo_ok = 1'b0;
          endcase
        end
        `APD_PFX_INDY: begin
          d.use_y = 1'b1;
          case (d.mode)
            apd_pkg::M_SIDX: d.mode = apd_pkg::M_SIIDX;
            apd_pkg::M_LIDX: d.mode = apd_pkg::M_LIIDX;
            default: begin
              d.combo_ok = 1'b0;
              d.use_y    = 1'b0;
            end
          endcase
        end
        default: d.combo_ok = 1'b1;
      endcase
      if (!d.combo_ok) begin
        d = apd_decode_base(op, d);
      end
    end
    case (d.mode)
      apd_pkg::M_INH, apd_pkg::M_IDX0:                   d.nops = 2'd0;
      apd_pkg::M_LDIR, apd_pkg::M_LIDX, apd_pkg::M_BITDR,
      apd_pkg::M_BITIR:                                  d.nops = 2'd2;
      default:                                           d.nops = 2'd1;
    endcase
    return d;
  endfunction

  // Undo a prebyte rewrite, keeping legality and group.
  function automatic apd_pkg::apd_dec_t apd_decode_base(input logic [7:0]        op,
                                                        input apd_pkg::apd_dec_t d);
    apd_pkg::apd_dec_t r;
    r          = d;
    r.use_y    = 1'b0;
    r.combo_ok = 1'b0;
    case (d.mode)
      apd_pkg::M_SIND:  r.mode = apd_pkg::M_SDIR;
      apd_pkg::M_LIND:  r.mode = apd_pkg::M_LDIR;
      apd_pkg::M_RELI:  r.mode = apd_pkg::M_RELD;
      apd_pkg::M_BITI:  r.mode = apd_pkg::M_BITD;
      apd_pkg::M_BITIR: r.mode = apd_pkg::M_BITDR;
      apd_pkg::M_SIIDX: r.mode = (op[7:4] == `APD_ROW_LIDX) ? apd_pkg::M_LIDX : apd_pkg::M_SIDX;
      apd_pkg::M_LIIDX: r.mode = apd_pkg::M_LIDX;
      default:          r.mode = d.mode;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Combinational helpers
  // --------------------------------------------------------------------------
  // Fetch requests are plain levels decoded from the state.
  always_comb begin
    dec_now  = apd_decode(pfx_ff, code_data);
    is_pfx   = (code_data == `APD_PFX_SWAP) || (code_data == `APD_PFX_INDY) ||
               (code_data == `APD_PFX_IND);
    need_ptr = (dec_ff.mode == apd_pkg::M_SIND)  || (dec_ff.mode == apd_pkg::M_LIND)  ||
               (dec_ff.mode == apd_pkg::M_SIIDX) || (dec_ff.mode == apd_pkg::M_LIIDX) ||
               (dec_ff.mode == apd_pkg::M_RELI)  || (dec_ff.mode == apd_pkg::M_BITI)  ||
               (dec_ff.mode == apd_pkg::M_BITIR);
    word_ptr = (dec_ff.mode == apd_pkg::M_LIND) || (dec_ff.mode == apd_pkg::M_LIIDX);
    code_req = (state_ff == apd_pkg::S_OP) || (state_ff == apd_pkg::S_B1) ||
               (state_ff == apd_pkg::S_B2);
    data_req = (state_ff == apd_pkg::S_PH) || (state_ff == apd_pkg::S_PL);
    busy     = (state_ff != apd_pkg::S_IDLE);
  end

  assign code_addr   = pc_ff;
  assign data_addr   = daddr_ff;
  assign done        = done_ff;
  assign illegal_rst = ill_ff;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // One byte is outstanding at a time; a request holds until its valid.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= apd_pkg::S_IDLE;
    end else begin
      case (state_ff)
        apd_pkg::S_IDLE: begin
          if (start) begin
            state_ff <= apd_pkg::S_OP;
          end
        end
        apd_pkg::S_OP: begin
          if (code_valid && !(is_pfx && pfx_ff == `APD_PFX_NONE)) begin
            if (!dec_now.legal) begin
              state_ff <= apd_pkg::S_IDLE;
            end else if (dec_now.nops == 2'd0) begin
              state_ff <= apd_pkg::S_CALC;
            end else begin
              state_ff <= apd_pkg::S_B1;
            end
          end
        end
        apd_pkg::S_B1: begin
          if (code_valid) begin
            state_ff <= (dec_ff.nops == 2'd2) ? apd_pkg::S_B2 :
                        need_ptr ? apd_pkg::S_PH : apd_pkg::S_CALC;
          end
        end
        apd_pkg::S_B2: begin
          if (code_valid) begin
            state_ff <= need_ptr ? apd_pkg::S_PH : apd_pkg::S_CALC;
          end
        end
        apd_pkg::S_PH: begin
          if (data_valid) begin
            state_ff <= word_ptr ? apd_pkg::S_PL : apd_pkg::S_CALC;
          end
        end
        apd_pkg::S_PL: begin
          if (data_valid) begin
            state_ff <= apd_pkg::S_CALC;
          end
        end
        apd_pkg::S_CALC: state_ff <= apd_pkg::S_IDLE;
        default:         state_ff <= apd_pkg::S_IDLE;
      endcase
    end
  end

  // Code-side capture: program counter, prebyte, opcode, operand bytes.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_ff  <= 16'h0000;
      pfx_ff <= `APD_PFX_NONE;
      op_ff  <= 8'h00;
      b1_ff  <= 8'h00;
      b2_ff  <= 8'h00;
      len_ff <= 3'h0;
      dec_ff <= '0;
    end else if (state_ff == apd_pkg::S_IDLE) begin
      if (start) begin
        pc_ff  <= start_pc;
        pfx_ff <= `APD_PFX_NONE;
        len_ff <= 3'h0;
      end
    end else if (code_req && code_valid) begin
      pc_ff  <= pc_ff + `APD_ADDR_ONE;
      len_ff <= len_ff + `APD_LEN_ONE;
      if (state_ff == apd_pkg::S_OP) begin
        if (is_pfx && pfx_ff == `APD_PFX_NONE) begin
          pfx_ff <= code_data;
        end else begin
          op_ff  <= code_data;
          dec_ff <= dec_now;
        end
      end else if (state_ff == apd_pkg::S_B1) begin
        b1_ff <= code_data;
      end else begin
        b2_ff <= code_data;
      end
    end
  end

  // Data-side pointer reads; word pointers sit high byte first.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      daddr_ff <= 16'h0000;
      ph_ff    <= 8'h00;
      pl_ff    <= 8'h00;
    end else begin
      // The pointer address is always the first byte after the opcode.
      if (state_ff == apd_pkg::S_B1 && code_valid) begin
        daddr_ff <= {`APD_PAGE_ZERO, code_data};
      end
      if (state_ff == apd_pkg::S_PH && data_valid) begin
        ph_ff    <= data_rdata;
        daddr_ff <= daddr_ff + `APD_ADDR_ONE;
      end
      if (state_ff == apd_pkg::S_PL && data_valid) begin
        pl_ff <= data_rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------------------
  // Index sums are unsigned, the relative target adds a sign-extended offset; all are 16 bits wide; long forms wrap at 64 Kbyte.
  always_comb begin
    idx      = dec_ff.use_y ? idx_y : idx_x;
    rel_off  = (dec_ff.mode == apd_pkg::M_RELI) ? ph_ff :
               ((dec_ff.mode == apd_pkg::M_BITDR) || (dec_ff.mode == apd_pkg::M_BITIR)) ?
               b2_ff : b1_ff;
    rel_base = {{8{rel_off[7]}}, rel_off};
    tgt_calc = pc_ff + rel_base;
    case (dec_ff.mode)
      apd_pkg::M_SDIR, apd_pkg::M_BITD, apd_pkg::M_BITDR: ea_calc = {`APD_PAGE_ZERO, b1_ff};
      apd_pkg::M_LDIR:  ea_calc = {b1_ff, b2_ff};
      apd_pkg::M_IDX0:  ea_calc = {`APD_PAGE_ZERO, idx};
      apd_pkg::M_SIDX:  ea_calc = {`APD_PAGE_ZERO, b1_ff} + {`APD_PAGE_ZERO, idx};
      apd_pkg::M_LIDX:  ea_calc = {b1_ff, b2_ff} + {`APD_PAGE_ZERO, idx};
      apd_pkg::M_SIND, apd_pkg::M_BITI, apd_pkg::M_BITIR: ea_calc = {`APD_PAGE_ZERO, ph_ff};
      apd_pkg::M_LIND:  ea_calc = {ph_ff, pl_ff};
      apd_pkg::M_SIIDX: ea_calc = {`APD_PAGE_ZERO, ph_ff} + {`APD_PAGE_ZERO, idx};
      apd_pkg::M_LIIDX: ea_calc = {ph_ff, pl_ff} + {`APD_PAGE_ZERO, idx};
      default:          ea_calc = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Result and pulses
  // --------------------------------------------------------------------------
  // The result holds until the next instruction completes.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result  <= '0;
      done_ff <= 1'b0;
      ill_ff  <= 1'b0;
    end else begin
      done_ff <= (state_ff == apd_pkg::S_CALC);
      ill_ff  <= (state_ff == apd_pkg::S_OP) && code_valid && !dec_now.legal &&
                 !(is_pfx && pfx_ff == `APD_PFX_NONE);
      if (state_ff == apd_pkg::S_CALC) begin
        result.ea        <= ea_calc;
        result.target    <= tgt_calc;
        result.next_pc   <= pc_ff;
        result.operand   <= b1_ff;
        result.opcode    <= op_ff;
        result.prefix    <= pfx_ff;
        result.mode      <= dec_ff.mode;
        result.group     <= dec_ff.group;
        result.len       <= len_ff;
        result.use_y     <= dec_ff.use_y;
        result.combo_bad <= !dec_ff.combo_ok;
      end
    end
  end

endmodule

`default_nettype wire

// ===== verif/apd_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module addressing_mode_prebyte_decoder_bench;
  logic clk, resetn, start, slow, cv, dv, creq, dreq, busy, done, ill;
  logic [15:0] spc, caddr, daddr;
  logic [7:0] cdat, ddat, ix, iy;
  apd_pkg::apd_result_t res;
  int num_errors = 0;
  int comparisons = 0;
  apd_decoder DUT (.clk(clk), .resetn(resetn), .start(start), .start_pc(spc),
    .code_valid(cv), .code_data(cdat), .data_valid(dv), .data_rdata(ddat), .idx_x(ix),
    .idx_y(iy), .code_req(creq), .code_addr(caddr), .data_req(dreq), .data_addr(daddr),
    .busy(busy), .done(done), .illegal_rst(ill), .result(res));
  apd_mem_model u_mem (.clk(clk), .slow(slow), .code_req(creq), .code_addr(caddr),
    .data_req(dreq), .data_addr(daddr), .code_valid(cv), .code_data(cdat),
    .data_valid(dv), .data_rdata(ddat));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compare one value and count it.
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Load up to four instruction bytes, first byte at the lowest address.
  task put(input logic [15:0] a, input logic [31:0] b);
    for (int i = 0; i < 4; i++) u_mem.mem[a[8:0] + i] = b[31 - 8 * i -: 8];
  endtask
  // Run one instruction; wait a bounded time for done or the illegal pulse.
  task run(input logic [15:0] pc, input logic [31:0] b);
    put(pc, b);
    @(posedge clk);
    start <= 1'b1;
    spc   <= pc;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 40 && !(done === 1'b1 || ill === 1'b1); i++) @(posedge clk) #1;
  endtask
  // Check mode, address (target for relative, value for immediate) and length.
  task exec(input logic [15:0] pc, input logic [31:0] b, input apd_pkg::apd_mode_t m,
            input logic [15:0] v, input logic [2:0] l);
    run(pc, b);
    chk({15'h0, done}, 16'h0001);
    chk({11'h0, res.mode}, {11'h0, m});
    chk((m == apd_pkg::M_RELD || m == apd_pkg::M_RELI) ? res.target :
        (m == apd_pkg::M_IMM) ? {8'h00, res.operand} : res.ea, v);
    chk({13'h0, res.len}, {13'h0, l});
    chk(res.next_pc, pc + {13'h0, l});
  endtask
  task t_direct;
    exec(16'h0100, 32'hB6100000, apd_pkg::M_SDIR, 16'h0010, 3'h2);
    chk({12'h0, res.group}, {12'h0, apd_pkg::G_LOAD});
    exec(16'h0108, 32'hC6123400, apd_pkg::M_LDIR, 16'h1234, 3'h3);
    exec(16'h0110, 32'hF6000000, apd_pkg::M_IDX0, 16'h00FF, 3'h1);
    exec(16'h0118, 32'hE6FF0000, apd_pkg::M_SIDX, 16'h01FE, 3'h2);
    exec(16'h0120, 32'hD6100000, apd_pkg::M_LIDX, 16'h10FF, 3'h3);
    exec(16'h0128, 32'h90F60000, apd_pkg::M_IDX0, 16'h0021, 3'h2);
    chk({15'h0, res.use_y}, 16'h0001);
    exec(16'h0130, 32'hA6770000, apd_pkg::M_IMM, 16'h0077, 3'h2);
  endtask
  // Pointer modes against a stalling memory.
  task t_indirect;
    slow <= 1'b1;
    exec(16'h0140, 32'h92B62000, apd_pkg::M_SIND, 16'h0055, 3'h3);
    exec(16'h0148, 32'h92C63000, apd_pkg::M_LIND, 16'hABCD, 3'h3);
    exec(16'h0150, 32'h92E62000, apd_pkg::M_SIIDX, 16'h0154, 3'h3);
    exec(16'h0158, 32'h91D63000, apd_pkg::M_LIIDX, 16'hABEE, 3'h3);
    slow <= 1'b0;
  endtask
  task t_relative;
    exec(16'h0160, 32'h20050000, apd_pkg::M_RELD, 16'h0167, 3'h2);
    exec(16'h0168, 32'h20F00000, apd_pkg::M_RELD, 16'h015A, 3'h2);
    exec(16'h0170, 32'h92204000, apd_pkg::M_RELI, 16'h0171, 3'h3);
  endtask
  task t_faults;
    run(16'h0178, 32'h31000000);
    chk({14'h0, ill, done}, 16'h0002);
    exec(16'h0180, 32'h91B61000, apd_pkg::M_SDIR, 16'h0010, 3'h3);
    chk({15'h0, res.combo_bad}, 16'h0001);
    exec(16'h0188, 32'h92012040, apd_pkg::M_BITIR, 16'h0055, 3'h4);
  endtask
  initial begin
    resetn = 1'b0;
    start  = 1'b0;
    spc    = 16'h0000;
    slow   = 1'b0;
    ix     = 8'hFF;
    iy     = 8'h21;
    u_mem.mem[9'h020] = 8'h55;
    u_mem.mem[9'h030] = 8'hAB;
    u_mem.mem[9'h031] = 8'hCD;
    u_mem.mem[9'h040] = 8'hFE;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_direct;
    t_indirect;
    t_relative;
    t_faults;
    conclude;
  end
  // Cut a hang short well beyond the expected run length.
  initial begin
    #20000;
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire

// ===== verif/apd_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port relations of the decoder.
// ----------------------------------------------------------------------------
module apd_decoder_props (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 start,
  input wire logic [15:0]          start_pc,
  input wire logic                 code_valid,
  input wire logic [7:0]           code_data,
  input wire logic                 data_valid,
  input wire logic [7:0]           data_rdata,
  input wire logic [7:0]           idx_x,
  input wire logic [7:0]           idx_y,
  input wire logic                 code_req,
  input wire logic [15:0]          code_addr,
  input wire logic                 data_req,
  input wire logic [15:0]          data_addr,
  input wire logic                 busy,
  input wire logic                 done,
  input wire logic                 illegal_rst,
  input wire apd_pkg::apd_result_t result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_code_hold: assert property (code_req && !code_valid |=> code_req && $stable(code_addr))
    else $error("code request dropped");
  a_code_step: assert property (code_req && code_valid |=> code_addr == $past(code_addr) + 16'h0001)
    else $error("code address not advanced");
  a_ptr_page: assert property (data_req |-> data_addr[15:8] == 8'h00)
    else $error("pointer outside page zero");
  a_len_range: assert property (done |-> result.len inside {[3'h1:3'h4]})
    else $error("length out of range");
  a_rel_target: assert property (done && result.mode == apd_pkg::M_RELD |->
    result.target == result.next_pc + {{8{result.operand[7]}}, result.operand})
    else $error("relative target wrong");
  a_sdir_page: assert property (done && result.mode == apd_pkg::M_SDIR |->
    result.ea == {8'h00, result.operand}) else $error("short direct address wrong");
  a_idx0_ea: assert property (done && result.mode == apd_pkg::M_IDX0 |->
    result.ea == {8'h00, (result.use_y ? $past(idx_y) : $past(idx_x))})
    else $error("index only address wrong");
  a_illegal_quiet: assert property (illegal_rst |-> !done && !busy)
    else $error("illegal code completed");
  a_idle_quiet: assert property (!busy |-> !code_req && !data_req)
    else $error("request while idle");
endmodule
bind apd_decoder apd_decoder_props u_props (.clk(clk), .resetn(resetn), .start(start),
  .start_pc(start_pc), .code_valid(code_valid), .code_data(code_data),
  .data_valid(data_valid), .data_rdata(data_rdata), .idx_x(idx_x), .idx_y(idx_y),
  .code_req(code_req), .code_addr(code_addr), .data_req(data_req), .data_addr(data_addr),
  .busy(busy), .done(done), .illegal_rst(illegal_rst), .result(result));
`default_nettype wire

// ===== verif/apd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Code and page-zero data memory behind the decoder fetch ports.
// ----------------------------------------------------------------------------
module apd_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        code_req,
  input  wire logic [15:0] code_addr,
  input  wire logic        data_req,
  input  wire logic [15:0] data_addr,
  output logic             code_valid,
  output logic [7:0]       code_data,
  output logic             data_valid,
  output logic [7:0]       data_rdata
);
  logic [7:0] mem [0:511];  // Words are loaded high byte first by the bench.
  logic       tick_ff = 1'b0; // Alternates so a slow memory answers every other cycle.
  // Toggle the wait phase each cycle.
  always @(posedge clk) begin
    tick_ff <= ~tick_ff;
  end
  // An idle bus shows the inverted byte so stale data cannot pass for valid data.
  assign code_valid = code_req & (~slow | tick_ff);
  assign data_valid = data_req & (~slow | tick_ff);
  assign code_data  = code_valid ? mem[code_addr[8:0]] : ~mem[code_addr[8:0]];
  assign data_rdata = data_valid ? mem[data_addr[8:0]] : ~mem[data_addr[8:0]];
endmodule
`default_nettype wire
